// ---- logic/rmtc_pkg.sv ----
// Constants shared by the ranging mode and trigger control block
package rmtc_pkg;
   // ==========================================================
   // Clock and derived times
   localparam int CLK_PERIOD_NS = 100;
   localparam int RTC_TICK_NS = 1000;
   localparam logic [15:0] RTC_TICK_CYC = 16'(RTC_TICK_NS / CLK_PERIOD_NS);
   localparam int TRIG_LAT_NS = 2000;
   localparam logic [15:0] TRIG_LAT_CYC = 16'((TRIG_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int EVT_PULSE_NS = 1000;
   localparam logic [15:0] EVT_PULSE_CYC =
      16'((EVT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // ==========================================================
   // Serial bus addresses and reset values
   localparam logic [6:0] PROG_ADDR = 7'h45;
   localparam logic [6:0] APP_ADDR_RST = 7'h29;
   localparam logic [15:0] SAMPLE_PERIOD_RST = 16'h0001;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage : rmtc_pkg

// ---- logic/rmtc_top.sv ----
// Measurement mode control, event line and two-address serial slave
`timescale 1ns/1ns
`default_nettype none
module rmtc_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Mode and measurement engine
   input wire logic mode_trig_i,
   input wire logic [15:0] sample_period_i,
   input wire logic meas_done_i,
   output logic meas_start_o,
   // Event line, three signals
   input wire logic evt_i,
   output logic evt_o,
   output logic evt_oe_n_o,
   // Serial bus pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // Application address reload
   input wire logic app_addr_load_i,
   input wire logic [6:0] app_addr_val_i,
   // Received bytes
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   output logic rx_prog_o,
   input wire logic rx_ready_i,
   input wire logic rx_ack_i,
   // Bytes to send
   output logic tx_req_o,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i
);
   // ==========================================================
   // Pin synchronisers: three stages, filtered on agreement
   logic [2:0] pin_in, s1_reg, s2_reg, s3_reg, filt_reg, filt_next, prev_reg;
   assign pin_in = {evt_i, scl_i, sda_i};
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         // Filter takes the third stage only when the second agrees with it
         always_comb begin
            filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
         end
         always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
               s1_reg[gi] <= 1'b1;
               s2_reg[gi] <= 1'b1;
               s3_reg[gi] <= 1'b1;
               filt_reg[gi] <= 1'b1;
               prev_reg[gi] <= 1'b1;
            end else begin
               s1_reg[gi] <= pin_in[gi];
               s2_reg[gi] <= s1_reg[gi];
               s3_reg[gi] <= s2_reg[gi];
               filt_reg[gi] <= filt_next[gi];
               prev_reg[gi] <= filt_reg[gi];
            end
         end
      end
   endgenerate
   logic evt_f, scl_f, sda_f, scl_p, sda_p;
   assign evt_f = filt_reg[2];
   assign scl_f = filt_reg[1];
   assign sda_f = filt_reg[0];
   assign scl_p = prev_reg[1];
   assign sda_p = prev_reg[0];

   // ==========================================================
   // Measurement sequencing
   typedef enum logic [1:0] {MS_IDLE, MS_LAT, MS_BUSY} rmtc_ms_type;
   rmtc_ms_type ms_reg, ms_next;
   logic [15:0] tick_reg, tick_next, per_reg, per_next, lat_reg, lat_next, pls_reg, pls_next;
   logic start_reg, start_next, evt_reg, evt_next, oe_n_reg, oe_n_next;
   logic tick, trig_take, free_fire, done_take;
   assign tick = (tick_reg == 16'h0000);
   // Own pulse is ignored as a trigger while we drive the line
   assign trig_take = mode_trig_i && (ms_reg == MS_IDLE) && oe_n_reg && evt_f && !prev_reg[2];
   assign free_fire = !mode_trig_i && tick && (per_reg == 16'h0000);
   assign done_take = (ms_reg == MS_BUSY) && meas_done_i;
   // Next state of the sequencer and event line
   always_comb begin
      ms_next = ms_reg;
      tick_next = tick ? rmtc_pkg::RTC_TICK_CYC - 16'h0001 : tick_reg - 16'h0001;
      per_next = per_reg;
      lat_next = lat_reg;
      pls_next = (pls_reg != 16'h0000) ? pls_reg - 16'h0001 : 16'h0000;
      start_next = 1'b0;
      if (free_fire) begin
         per_next = sample_period_i - 16'h0001; // Period counts on the slow tick
      end else if (tick && !mode_trig_i) begin
         per_next = per_reg - 16'h0001;
      end
      case (ms_reg)
         MS_IDLE: begin
            if (free_fire) begin
               start_next = 1'b1;
               ms_next = MS_BUSY;
            end else if (trig_take) begin
               lat_next = rmtc_pkg::TRIG_LAT_CYC - 16'h0001;
               ms_next = MS_LAT;
            end
         end
         MS_LAT: begin
            // Fixed count, no dependence on tick phase
            if (lat_reg == 16'h0000) begin
               start_next = 1'b1;
               ms_next = MS_BUSY;
            end else begin
               lat_next = lat_reg - 16'h0001;
            end
         end
         MS_BUSY: begin
            // A late sample slips the next period rather than overlapping
            if (meas_done_i) begin
               pls_next = rmtc_pkg::EVT_PULSE_CYC;
               ms_next = MS_IDLE;
            end
         end
         default: ms_next = MS_IDLE;
      endcase
      evt_next = (pls_next != 16'h0000);
      oe_n_next = mode_trig_i && !evt_next;
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ms_reg <= MS_IDLE;
         tick_reg <= 16'h0000;
         per_reg <= rmtc_pkg::SAMPLE_PERIOD_RST;
         lat_reg <= 16'h0000;
         pls_reg <= 16'h0000;
         start_reg <= 1'b0;
         evt_reg <= 1'b0;
         oe_n_reg <= 1'b0;
      end else begin
         ms_reg <= ms_next;
         tick_reg <= tick_next;
         per_reg <= per_next;
         lat_reg <= lat_next;
         pls_reg <= pls_next;
         start_reg <= start_next;
         evt_reg <= evt_next;
         oe_n_reg <= oe_n_next;
      end
   end
   assign meas_start_o = start_reg;
   assign evt_o = evt_reg;
   assign evt_oe_n_o = oe_n_reg;

   // ==========================================================
   // Serial slave
   typedef enum logic [2:0] {IS_IDLE, IS_ADDR, IS_STR, IS_ACK, IS_RX, IS_TX, IS_MACK} rmtc_is_type;
   rmtc_is_type is_reg, is_next;
   logic [7:0] sh_reg, sh_next, rxd_reg, rxd_next;
   logic [3:0] bc_reg, bc_next;
   logic [6:0] app_reg, app_next;
   logic rd_reg, rd_next, pg_reg, pg_next, first_reg, first_next, ackv_reg, ackv_next;
   logic sclh_reg, sclh_next, sdal_reg, sdal_next, rxv_reg, rxv_next, txr_reg, txr_next;
   logic rise, fall, start_c, stop_c, addr_hit, last_bit;
   assign rise = scl_f && !scl_p;
   assign fall = !scl_f && scl_p;
   assign start_c = scl_f && scl_p && sda_p && !sda_f;
   assign stop_c = scl_f && scl_p && !sda_p && sda_f;
   assign addr_hit = (sh_reg[7:1] == rmtc_pkg::PROG_ADDR) || (sh_reg[7:1] == app_reg);
   assign last_bit = fall && (bc_reg == rmtc_pkg::BITS_PER_BYTE);
   // Next state of the byte engine
   always_comb begin
      is_next = is_reg;
      sh_next = sh_reg;
      rxd_next = rxd_reg;
      bc_next = bc_reg;
      rd_next = rd_reg;
      pg_next = pg_reg;
      first_next = first_reg;
      ackv_next = ackv_reg;
      sclh_next = sclh_reg;
      sdal_next = sdal_reg;
      rxv_next = rxv_reg;
      txr_next = 1'b0;
      app_next = app_load_sel(app_addr_load_i, app_addr_val_i, app_reg);
      if ((is_reg == IS_ADDR || is_reg == IS_RX || is_reg == IS_TX) && rise) begin
         sh_next = (is_reg == IS_TX) ? sh_reg : {sh_reg[6:0], sda_f};
         bc_next = bc_reg + 4'h1;
      end
      case (is_reg)
         IS_ADDR: begin
            if (last_bit) begin
               if (addr_hit) begin
                  rd_next = sh_reg[0];
                  pg_next = (sh_reg[7:1] == rmtc_pkg::PROG_ADDR);
                  first_next = 1'b1;
                  ackv_next = 1'b1;
                  sclh_next = 1'b1;
                  txr_next = sh_reg[0];
                  is_next = IS_STR;
               end else begin
                  is_next = IS_IDLE;
               end
            end
         end
         IS_RX: begin
            if (last_bit) begin
               rxd_next = sh_reg;
               rxv_next = 1'b1;
               sclh_next = 1'b1;
               is_next = IS_STR;
            end
         end
         IS_STR: begin
            // Clock stays low until the user side is ready
            if (rxv_reg) begin
               if (rx_ready_i) begin
                  rxv_next = 1'b0;
                  ackv_next = rx_ack_i;
                  sdal_next = rx_ack_i;
                  sclh_next = 1'b0;
                  is_next = IS_ACK;
               end
            end else if (rd_reg) begin
               if (tx_valid_i) begin
                  sh_next = tx_data_i;
                  sdal_next = first_reg;
                  sclh_next = 1'b0;
                  is_next = first_reg ? IS_ACK : IS_MACK;
               end
            end else begin
               sdal_next = 1'b1;
               sclh_next = 1'b0;
               is_next = IS_ACK;
            end
         end
         IS_ACK: begin
            if (fall) begin
               bc_next = 4'h0;
               first_next = 1'b0;
               sdal_next = rd_reg && ackv_reg && !sh_reg[7];
               is_next = !ackv_reg ? IS_IDLE : (rd_reg ? IS_TX : IS_RX);
            end
         end
         IS_TX: begin
            if (last_bit) begin
               sdal_next = 1'b0;
               sclh_next = 1'b1;
               txr_next = 1'b1;
               is_next = IS_STR;
            end else if (fall) begin
               sh_next = {sh_reg[6:0], 1'b0};
               sdal_next = !sh_reg[6];
            end
         end
         IS_MACK: begin
            // Master ack is read only after the next byte is loaded
            if (rise && sda_f) begin
               is_next = IS_IDLE;
            end else if (fall) begin
               bc_next = 4'h0;
               sdal_next = !sh_reg[7];
               is_next = IS_TX;
            end
         end
         IS_IDLE: is_next = IS_IDLE;
         default: is_next = IS_IDLE;
      endcase
      if (start_c || stop_c) begin
         is_next = start_c ? IS_ADDR : IS_IDLE;
         bc_next = 4'h0;
         sclh_next = 1'b0;
         sdal_next = 1'b0;
         rxv_next = 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         is_reg <= IS_IDLE;
         sh_reg <= 8'h00;
         rxd_reg <= 8'h00;
         bc_reg <= 4'h0;
         rd_reg <= 1'b0;
         pg_reg <= 1'b0;
         first_reg <= 1'b0;
         ackv_reg <= 1'b0;
         sclh_reg <= 1'b0;
         sdal_reg <= 1'b0;
         rxv_reg <= 1'b0;
         txr_reg <= 1'b0;
         app_reg <= rmtc_pkg::APP_ADDR_RST;
      end else begin
         is_reg <= is_next;
         sh_reg <= sh_next;
         rxd_reg <= rxd_next;
         bc_reg <= bc_next;
         rd_reg <= rd_next;
         pg_reg <= pg_next;
         first_reg <= first_next;
         ackv_reg <= ackv_next;
         sclh_reg <= sclh_next;
         sdal_reg <= sdal_next;
         rxv_reg <= rxv_next;
         txr_reg <= txr_next;
         app_reg <= app_next;
      end
   end
   function automatic logic [6:0] app_load_sel(input logic ld, input logic [6:0] v,
                                              input logic [6:0] cur);
      app_load_sel = ld ? v : cur;
   endfunction : app_load_sel
   // Pins only ever pull low; level comes from the enable
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_n_o = !sclh_reg;
   assign sda_oe_n_o = !sdal_reg;
   assign rx_data_o = rxd_reg;
   assign rx_valid_o = rxv_reg;
   assign rx_prog_o = pg_reg;
   assign tx_req_o = txr_reg;

   // ==========================================================
   // Checks
   localparam int AST_LAT = int'(rmtc_pkg::TRIG_LAT_CYC) + 1;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   AST_FREE_START: assert property (free_fire && ms_reg == MS_IDLE |=> meas_start_o)
      else $error("free-running start missed");
   AST_FREE_DRIVE: assert property (!mode_trig_i && !$past(mode_trig_i) |-> !evt_oe_n_o)
      else $error("event line released in free-running mode");
   AST_EVT_PULSE: assert property (done_take |=> evt_o [*8])
      else $error("sample pulse too short");
   AST_TRIG_IDLE: assert property (mode_trig_i && ms_reg == MS_IDLE |=> !meas_start_o)
      else $error("start without trigger");
   AST_TRIG_LAT: assert property (trig_take |-> ##AST_LAT meas_start_o)
      else $error("trigger latency wrong");
   AST_ADDR_MISS: assert property (is_reg == IS_ADDR && last_bit && !addr_hit && !start_c
      |=> is_reg == IS_IDLE && sda_oe_n_o)
      else $error("foreign address acknowledged");
   AST_STRETCH: assert property ((is_reg == IS_RX || is_reg == IS_TX) && last_bit && !start_c
      && !stop_c |=> !scl_oe_n_o)
      else $error("clock not held after eighth bit");
   AST_HOLD_TX: assert property (is_reg == IS_STR && !rxv_reg && rd_reg && !tx_valid_i
      && !start_c && !stop_c |=> !scl_oe_n_o && is_reg == IS_STR)
      else $error("clock released before byte ready");
   COV_FREE: cover property (free_fire ##1 meas_start_o);
   COV_TRIG: cover property (trig_take ##AST_LAT meas_start_o);
   COV_READ: cover property (is_reg == IS_STR && rd_reg && tx_valid_i);
endmodule : rmtc_top
`default_nettype wire

// ---- verification/rmtc_host_model.sv ----
// Host model: serial bus master and trigger driver for one sensor
`timescale 1ns/1ns
`default_nettype none
module rmtc_host_model (
   // Clock
   input wire logic clk_i,
   // Device pin drives
   input wire logic scl_oe_n_i,
   input wire logic sda_oe_n_i,
   input wire logic evt_oe_n_i,
   input wire logic evt_drv_i,
   // Resolved lines
   output logic scl_w_o,
   output logic sda_w_o,
   output logic evt_w_o
);
   logic scl_m = 1'b1;
   logic sda_m = 1'b1;
   logic evt_m = 1'b0;
   // ==========================================================
   // Line resolution
   // Bus lines are wired-and with pull-ups; host idles its trigger low
   assign scl_w_o = scl_m & scl_oe_n_i;
   assign sda_w_o = sda_m & sda_oe_n_i;
   assign evt_w_o = evt_oe_n_i ? evt_m : evt_drv_i;
   // ==========================================================
   // Bus tasks, third of a bit of 8 cycles to clear the pin synchroniser
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   task automatic line(input logic c, input logic d);
      scl_m <= c;
      sda_m <= d;
      tick(8);
   endtask : line
   task automatic start_c();
      line(1'b0, 1'b1);
      line(1'b1, 1'b1);
      line(1'b1, 1'b0);
      line(1'b0, 1'b0);
   endtask : start_c
   task automatic stop_c();
      line(1'b0, 1'b0);
      line(1'b1, 1'b0);
      line(1'b1, 1'b1);
   endtask : stop_c
   // One bit; a stretched clock is waited out, a stuck one gives x
   task automatic bit_cyc(input logic b, output logic s);
      int i;
      sda_m <= b;
      tick(8);
      scl_m <= 1'b1;
      for (i = 0; i < 400 && scl_w_o !== 1'b1; i++) tick(1);
      tick(8);
      s = (i < 400) ? sda_w_o : 1'bx;
      scl_m <= 1'b0;
      tick(8);
   endtask : bit_cyc
   task automatic wr_byte(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
   endtask : wr_byte
   // Each sensor gets its own pulse, which fixes its start time
   task automatic trig();
      evt_m <= 1'b1;
      tick(5);
      evt_m <= 1'b0;
   endtask : trig
endmodule : rmtc_host_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// Testbench for the ranging mode and trigger control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic mode_trig_i = 1'b0;
   logic [15:0] sample_period_i = 16'h0002;
   logic meas_done_i = 1'b0;
   logic app_addr_load_i = 1'b0;
   logic [6:0] app_addr_val_i = 7'h00;
   logic rx_ready_i = 1'b0;
   logic rx_ack_i = 1'b0;
   logic [7:0] tx_data_i = 8'h00;
   logic tx_valid_i = 1'b0;
   logic meas_start_o, evt_o, evt_oe_n_o, scl_oe_n_o, sda_oe_n_o;
   logic rx_valid_o, rx_prog_o, tx_req_o, scl_w, sda_w, evt_w;
   logic [7:0] rx_data_o;
   int bad_count = 0;
   int checks = 0;
   int hi, oe_hi;
   // ==========================================================
   // Design and host
   rmtc_top i_rmtc_top (.clk_i, .sys_rst_i, .mode_trig_i, .sample_period_i,
      .meas_done_i, .meas_start_o, .evt_i(evt_w), .evt_o, .evt_oe_n_o,
      .scl_i(scl_w), .scl_o(), .scl_oe_n_o, .sda_i(sda_w), .sda_o(), .sda_oe_n_o,
      .app_addr_load_i, .app_addr_val_i, .rx_data_o, .rx_valid_o, .rx_prog_o,
      .rx_ready_i, .rx_ack_i, .tx_req_o, .tx_data_i, .tx_valid_i);
   rmtc_host_model i_rmtc_host_model (.clk_i, .scl_oe_n_i(scl_oe_n_o),
      .sda_oe_n_i(sda_oe_n_o), .evt_oe_n_i(evt_oe_n_o), .evt_drv_i(evt_o),
      .scl_w_o(scl_w), .sda_w_o(sda_w), .evt_w_o(evt_w));
   // 100 ns clock
   initial forever #50 clk_i = ~clk_i;
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t ns: %h not %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   // Step until a start pulse or the limit, tallying the event line
   task automatic run(input int lim, output int n);
      for (n = 1; n <= lim; n++) begin
         @(posedge clk_i);
         #1;
         hi += int'(evt_o);
         oe_hi += int'(evt_oe_n_o);
         if (meas_start_o === 1'b1) break;
      end
   endtask : run
   task automatic wait_start(output int n);
      run(200, n);
      if (n > 200) begin
         bad_count++;
         conclude();
      end
   endtask : wait_start
   task automatic pulse_done();
      @(posedge clk_i) meas_done_i <= 1'b1;
      @(posedge clk_i) meas_done_i <= 1'b0;
   endtask : pulse_done
   // Byte is handed over only while the clock is stretched
   task automatic give_tx(input logic [7:0] d);
      #1;
      check(scl_oe_n_o, 16'h0000);
      @(posedge clk_i) tx_data_i <= d;
      tx_valid_i <= 1'b1;
      @(posedge clk_i) tx_valid_i <= 1'b0;
   endtask : give_tx
   task automatic send(input logic [7:0] b);
      i_rmtc_host_model.start_c();
      i_rmtc_host_model.wr_byte(b);
   endtask : send
   // ==========================================================
   // Scenarios
   task automatic t_free();
      int n;
      wait_start(n);
      pulse_done();
      // The pulse rises on the edge that takes done, so count that edge too
      #1;
      hi = int'(evt_o);
      oe_hi = int'(evt_oe_n_o);
      wait_start(n);
      check(16'(n), 16'h0012);
      check(16'(hi), 16'h000A);
      check(16'(oe_hi), 16'h0000);
      pulse_done();
      repeat (14) @(posedge clk_i);
      mode_trig_i <= 1'b1;
   endtask : t_free
   task automatic t_trig();
      int n0, n1, n;
      run(100, n);
      check(16'(n), 16'h0065);
      check(evt_oe_n_o, 16'h0001);
      i_rmtc_host_model.trig();
      wait_start(n0);
      // A trigger while busy is dropped
      i_rmtc_host_model.trig();
      run(60, n);
      check(16'(n), 16'h003D);
      pulse_done();
      // Thirty samples in all, the first taken on the done edge
      #1;
      hi = int'(evt_o);
      oe_hi = int'(evt_oe_n_o);
      run(29, n);
      check(16'(hi), 16'h000A);
      check(16'(oe_hi), 16'h0014);
      i_rmtc_host_model.trig();
      wait_start(n1);
      check(16'(n1), 16'(n0));
      check(16'(n0 + 5 >= 21), 16'h0001);
   endtask : t_trig
   task automatic t_addr();
      logic [7:0] tab [5] = '{8'h29, 8'h45, 8'h30, 8'h11, 8'h29};
      logic [4:0] nak = 5'b10100;
      logic a;
      for (int i = 0; i < 5; i++) begin
         if (i == 3) begin
            @(posedge clk_i) app_addr_val_i <= 7'h11;
            app_addr_load_i <= 1'b1;
            @(posedge clk_i) app_addr_load_i <= 1'b0;
         end
         send({tab[i][6:0], 1'b0});
         i_rmtc_host_model.bit_cyc(1'b1, a);
         check(a, 16'(nak[i]));
         i_rmtc_host_model.stop_c();
      end
   endtask : t_addr
   // Write to the loader address; byte waits with clock held low
   task automatic t_data();
      logic a;
      send(8'h8A);
      i_rmtc_host_model.bit_cyc(1'b1, a);
      check(a, 16'h0000);
      i_rmtc_host_model.wr_byte(8'h3C);
      repeat (30) @(posedge clk_i);
      #1;
      check(scl_oe_n_o, 16'h0000);
      check({rx_valid_o, rx_prog_o, rx_data_o}, 16'h033C);
      @(posedge clk_i) rx_ready_i <= 1'b1;
      rx_ack_i <= 1'b1;
      @(posedge clk_i) rx_ready_i <= 1'b0;
      i_rmtc_host_model.bit_cyc(1'b1, a);
      check(a, 16'h0000);
      i_rmtc_host_model.stop_c();
   endtask : t_data
   // Read one sample byte from the application address
   task automatic t_read();
      logic a;
      logic [7:0] d;
      send(8'h23);
      give_tx(8'hA5);
      i_rmtc_host_model.bit_cyc(1'b1, a);
      check(a, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         i_rmtc_host_model.bit_cyc(1'b1, a);
         d = {d[6:0], a};
      end
      give_tx(8'h5A);
      i_rmtc_host_model.bit_cyc(1'b1, a);
      check(d, 16'h00A5);
      i_rmtc_host_model.stop_c();
   endtask : t_read
   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1;
      check(evt_oe_n_o, 16'h0000);
      @(posedge clk_i);
      #1;
      check({meas_start_o, scl_oe_n_o, sda_oe_n_o, rx_valid_o, tx_req_o}, 16'h000C);
      t_free();
      t_trig();
      t_addr();
      t_data();
      t_read();
      conclude();
   end
endmodule : tb_top
`default_nettype wire
